// *** logic/ugef_top.sv ***
// global event flag register of the full-speed controller, AHB-Lite slave
module ugef_top #(
  parameter int IDLE_CYCLES = ugef_pkg::IDLE_CYCLES, // bus idle time before suspend
  parameter int FW          = 9,                     // FIFO word count width
  parameter int NPTX_DEPTH  = 256                    // non-periodic tx FIFO depth
) (
  input  wire logic          SYS_CLK,          // system clock
  input  wire logic          RST_N,            // synchronous reset, active low
  input  wire logic          HSEL,             // slave select
  input  wire logic [31:0]   HADDR,            // byte address
  input  wire logic [1:0]    HTRANS,           // transfer type
  input  wire logic          HWRITE,           // write when high
  input  wire logic [2:0]    HSIZE,            // transfer size
  input  wire logic [31:0]   HWDATA,           // write data
  input  wire logic          HREADY,           // bus ready
  output logic      [31:0]   HRDATA,           // read data
  output logic               HREADYOUT,        // slave ready
  output logic               HRESP,            // response, always okay
  input  wire logic          ROLE_HOST,        // current role, high for host
  input  wire logic          HC_IRQ,           // any host channel request
  input  wire logic          HPORT_IRQ,        // any port change cause
  input  wire logic          OEP_IRQ,          // any OUT endpoint request
  input  wire logic          IEP_IRQ,          // any IN endpoint request
  input  wire logic          OTG_IRQ,          // any OTG event cause
  input  wire logic          FRAME_END,        // host frame end pulse
  input  wire logic          PERIODIC_PENDING, // host periodic work left
  input  wire logic [13:0]   BUS_TIME,         // bit times into frame
  input  wire logic          ISO_IN_PENDING,   // iso IN work left
  input  wire logic          ISO_OUT_PENDING,  // iso OUT work left
  input  wire logic          ISO_OUT_PKT,      // iso OUT packet arrives
  input  wire logic [FW-1:0] ISO_OUT_LEN,      // its length in words
  input  wire logic [FW-1:0] RX_FREE,          // free rx FIFO words
  input  wire logic [FW-1:0] RX_ENTRIES,       // entries in rx FIFO
  input  wire logic [FW-1:0] NPTX_FREE,        // free tx FIFO words
  input  wire logic          ENUM_DONE,        // speed enumeration done pulse
  input  wire logic [1:0]    ENUM_SPEED,       // enumerated speed
  input  wire logic          BUS_RESET,        // reset signalling seen pulse
  input  wire logic          BUS_IDLE,         // bus idle level
  input  wire logic          SOF_PREPARE,      // host SOF about to go pulse
  input  wire logic          SOF_RX,           // device SOF token pulse
  input  wire logic [10:0]   FRAME_NUM,        // received frame number
  input  wire logic          XFER_IDLE,        // no transaction in progress
  output logic               OUT_NAK_REQ,      // global OUT NAK requested
  output logic               IN_NAK_REQ,       // global IN NAK requested
  output logic               SUSPENDED,        // device in suspend state
  output logic               HOST_SOF_EN       // host frame generation on
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int ICW = $clog2(IDLE_CYCLES + 1);

  typedef struct packed {
    ugef_pkg::ugef_bus_t bus;
    logic [11:0]         wa;
    logic [31:0]         rdata;
    logic [31:0]         flags;
    logic [ICW-1:0]      idle_cnt;
    logic                sleep;
    logic [13:0]         btime;
    logic                out_req;
    logic                in_req;
    logic                out_act;
    logic                in_act;
    logic                tx_fifo_threshold_select;
    logic [1:0]          periodic_frame_end_time;
    logic [1:0]          speed;
    logic [10:0]         fnum;
    logic                sof_en;
  } ugef_state_t;

  localparam ugef_state_t ST_RESET = '{bus: ugef_pkg::BUS_IDLE, default: '0};

  ugef_state_t st_q;
  ugef_state_t st_d;

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  // true when the register may be touched in the given role
  function automatic logic access_ok(input logic [11:0] a, input logic host);
    logic dev_only;
    logic host_only;
    dev_only  = (a == ugef_pkg::ADDR_DEVCFG) || (a == ugef_pkg::ADDR_DEVCTL) ||
                (a == ugef_pkg::ADDR_DEVSTAT);
    host_only = (a == ugef_pkg::ADDR_HOSTCFG);
    return !((dev_only && host) || (host_only && !host));
  endfunction : access_ok

  // periodic frame end point in bit times
  function automatic logic [13:0] pf_limit(input logic [1:0] sel);
    int pct;
    unique case (sel)
      2'd0: pct = ugef_pkg::PF_PCT0;
      2'd1: pct = ugef_pkg::PF_PCT1;
      2'd2: pct = ugef_pkg::PF_PCT2;
      2'd3: pct = ugef_pkg::PF_PCT3;
    endcase
    return 14'(ugef_pkg::FRAME_BITS * pct / 100);
  endfunction : pf_limit

  logic        host;
  logic        aph;
  logic        rd_flags;
  logic        pf_hit;
  logic        nptx_low;
  logic        sof_set;
  logic [31:0] sets;
  logic [31:0] live;
  logic [31:0] rd_val;
  logic [31:0] clr;

  assign host = ROLE_HOST;
  assign aph  = HSEL && HTRANS[1] && HREADY;
  assign rd_flags = aph && !HWRITE && (HADDR[11:0] == ugef_pkg::ADDR_FLAGS);

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // crossing test, so a bus time that jumps past the point still hits once
  assign pf_hit = !host && (BUS_TIME >= pf_limit(st_q.periodic_frame_end_time)) &&
                  (st_q.btime < pf_limit(st_q.periodic_frame_end_time));
  // threshold select low means half empty, high means completely empty
  assign nptx_low = host && (st_q.tx_fifo_threshold_select ? (NPTX_FREE == FW'(NPTX_DEPTH)) :
                             (NPTX_FREE >= FW'(NPTX_DEPTH / 2)));
  assign sof_set = (host && SOF_PREPARE) || (!host && SOF_RX);

  // sticky events; they set whatever the interrupt enables say
  always_comb begin
    sets = '0;
    sets[ugef_pkg::B_PINC]    = (host && FRAME_END && PERIODIC_PENDING) ||
                                (pf_hit && ISO_OUT_PENDING);
    sets[ugef_pkg::B_ISOIN]   = pf_hit && ISO_IN_PENDING;
    sets[ugef_pkg::B_PFEND]   = pf_hit;
    sets[ugef_pkg::B_ISODROP] = !host && ISO_OUT_PKT && (RX_FREE < ISO_OUT_LEN);
    sets[ugef_pkg::B_ENUM]    = !host && ENUM_DONE;
    sets[ugef_pkg::B_BRST]    = !host && BUS_RESET;
    // fires once per idle stretch, so a held count cannot re-set a cleared flag
    sets[ugef_pkg::B_IDLEW]   = !host && BUS_IDLE && !st_q.sleep &&
                                (st_q.idle_cnt == ICW'(IDLE_CYCLES - 1));
    sets[ugef_pkg::B_SLEEP]   = sets[ugef_pkg::B_IDLEW];
    sets[ugef_pkg::B_SOF]     = sof_set;
    sets[ugef_pkg::B_MFLT]    = aph && !access_ok(HADDR[11:0], host);
  end

  // level bits follow their causes and clear with them
  always_comb begin
    live = '0;
    live[ugef_pkg::B_HCH]    = host && HC_IRQ;
    live[ugef_pkg::B_HPORT]  = host && HPORT_IRQ;
    live[ugef_pkg::B_OEP]    = !host && OEP_IRQ;
    live[ugef_pkg::B_IEP]    = !host && IEP_IRQ;
    live[ugef_pkg::B_OUTNAK] = st_q.out_act;
    live[ugef_pkg::B_INNAK]  = st_q.in_act;
    live[ugef_pkg::B_NPTX]   = nptx_low;
    live[ugef_pkg::B_RXNE]   = (RX_ENTRIES != '0);
    live[ugef_pkg::B_OTG]    = OTG_IRQ;
    live[ugef_pkg::B_ROLE]   = host;
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  // unmapped and wrong-role reads return zero
  always_comb begin
    rd_val = ugef_pkg::RESET_WORD;
    if (access_ok(HADDR[11:0], host)) begin
      unique case (HADDR[11:0])
        ugef_pkg::ADDR_BUSCFG:  rd_val[0] = st_q.tx_fifo_threshold_select;
        ugef_pkg::ADDR_DEVCFG:  rd_val[1:0] = st_q.periodic_frame_end_time;
        ugef_pkg::ADDR_DEVCTL:  rd_val[1:0] = {st_q.in_req, st_q.out_req};
        ugef_pkg::ADDR_DEVSTAT: begin
          rd_val[0] = st_q.sleep;
          rd_val[ugef_pkg::DSTAT_SPD +: 2] = st_q.speed;
          rd_val[ugef_pkg::DSTAT_FNUM +: 11] = st_q.fnum;
        end
        ugef_pkg::ADDR_HOSTCFG: rd_val[0] = st_q.sof_en;
        ugef_pkg::ADDR_FLAGS:   rd_val = st_q.flags | live;
        default:                rd_val = ugef_pkg::RESET_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    clr  = '0;
    // bus slave: address phase decides, data phase writes
    unique case (st_q.bus)
      ugef_pkg::BUS_IDLE,
      ugef_pkg::BUS_WR,
      ugef_pkg::BUS_RD: begin
        if (st_q.bus == ugef_pkg::BUS_WR) begin
          unique case (st_q.wa)
            ugef_pkg::ADDR_BUSCFG:  st_d.tx_fifo_threshold_select = HWDATA[0];
            ugef_pkg::ADDR_DEVCFG:  st_d.periodic_frame_end_time = HWDATA[1:0];
            ugef_pkg::ADDR_DEVCTL: begin
              if (HWDATA[ugef_pkg::DCTL_SET_OUT]) st_d.out_req = 1'b1;
              if (HWDATA[ugef_pkg::DCTL_SET_IN]) st_d.in_req = 1'b1;
              if (HWDATA[ugef_pkg::DCTL_CLR_OUT]) st_d.out_req = 1'b0;
              if (HWDATA[ugef_pkg::DCTL_CLR_IN]) st_d.in_req = 1'b0;
            end
            ugef_pkg::ADDR_HOSTCFG: st_d.sof_en = HWDATA[0];
            ugef_pkg::ADDR_FLAGS:   clr = HWDATA & ugef_pkg::W1C_MASK;
            default:                clr = '0;
          endcase
        end
        st_d.bus = ugef_pkg::BUS_IDLE;
        if (aph && HWRITE && access_ok(HADDR[11:0], host) &&
            (HSIZE == 3'b010)) begin
          st_d.bus = ugef_pkg::BUS_WR;
          st_d.wa  = HADDR[11:0];
        end else if (aph && !HWRITE) begin
          st_d.bus   = ugef_pkg::BUS_RD;
          st_d.rdata = rd_val;
        end
      end
    endcase
    // a set in the same cycle as its clear wins
    st_d.flags = ((st_q.flags & ~clr) | sets) & ugef_pkg::W1C_MASK;
    // idle counter and suspend state
    if (!BUS_IDLE || host) begin
      st_d.idle_cnt = '0;
      st_d.sleep    = 1'b0;
    end else if (st_q.idle_cnt != ICW'(IDLE_CYCLES - 1)) begin
      st_d.idle_cnt = st_q.idle_cnt + ICW'(1);
    end else begin
      st_d.sleep = 1'b1;
    end
    st_d.btime = BUS_TIME;
    // NAK becomes effective only between transactions
    if (!st_d.out_req) begin
      st_d.out_act = 1'b0;
    end else if (st_q.out_req && XFER_IDLE) begin
      st_d.out_act = 1'b1;
    end
    if (!st_d.in_req) begin
      st_d.in_act = 1'b0;
    end else if (st_q.in_req && XFER_IDLE) begin
      st_d.in_act = 1'b1;
    end
    if (!host && ENUM_DONE) begin
      st_d.speed = ENUM_SPEED;
    end
    if (!host && SOF_RX) begin
      st_d.fnum = FRAME_NUM;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs; zero wait states keep the master free to pipeline
  assign HRDATA      = st_q.rdata;
  assign HREADYOUT   = 1'b1;
  assign HRESP       = 1'b0;
  assign OUT_NAK_REQ = st_q.out_req;
  assign IN_NAK_REQ  = st_q.in_req;
  assign SUSPENDED   = st_q.sleep;
  assign HOST_SOF_EN = st_q.sof_en;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_hch_summary: assert property (
    rd_flags && ROLE_HOST && HC_IRQ |=> HRDATA[ugef_pkg::B_HCH])
    else $error("channel summary not reported");
  a_hport_clear: assert property (
    rd_flags && !(ROLE_HOST && HPORT_IRQ) |=> !HRDATA[ugef_pkg::B_HPORT])
    else $error("port flag stuck without cause");
  a_pinc_set: assert property (
    ROLE_HOST && FRAME_END && PERIODIC_PENDING |=> st_q.flags[ugef_pkg::B_PINC])
    else $error("periodic incomplete not set");
  a_isoin_set: assert property (
    pf_hit && ISO_IN_PENDING |=> st_q.flags[ugef_pkg::B_ISOIN] &&
    st_q.flags[ugef_pkg::B_PFEND])
    else $error("iso IN incomplete not set");
  a_idle_flags: assert property (
    !ROLE_HOST && BUS_IDLE && !SUSPENDED && st_q.idle_cnt == ICW'(IDLE_CYCLES - 1)
    |=> st_q.flags[ugef_pkg::B_IDLEW] && st_q.flags[ugef_pkg::B_SLEEP] && SUSPENDED)
    else $error("idle warning or suspend missing");
  a_nak_effect: assert property (
    $rose(st_q.out_act) |-> $past(st_q.out_req) && $past(XFER_IDLE))
    else $error("out NAK flag before request took effect");
  a_mode_fault: assert property (
    aph && !access_ok(HADDR[11:0], ROLE_HOST)
    |=> st_q.flags[ugef_pkg::B_MFLT] && st_q.bus != ugef_pkg::BUS_WR)
    else $error("wrong-role access not faulted");
  a_set_wins: assert property (
    st_q.bus == ugef_pkg::BUS_WR && st_q.wa == ugef_pkg::ADDR_FLAGS &&
    HWDATA[ugef_pkg::B_SOF] && sof_set |=> st_q.flags[ugef_pkg::B_SOF])
    else $error("clear beat a same-cycle set");
  a_rxne_level: assert property (
    rd_flags && RX_ENTRIES != '0 |=> HRDATA[ugef_pkg::B_RXNE])
    else $error("rx not empty not reported");
  a_role_bit: assert property (
    rd_flags |=> HRDATA[ugef_pkg::B_ROLE] == $past(ROLE_HOST))
    else $error("role bit wrong");

  // single-cycle events and summaries as software sees them
  a_sof_set: assert property (
    (ROLE_HOST && SOF_PREPARE) || (!ROLE_HOST && SOF_RX) |=> st_q.flags[ugef_pkg::B_SOF])
    else $error("start of frame flag not set");
  a_drop_set: assert property (
    !ROLE_HOST && ISO_OUT_PKT && RX_FREE < ISO_OUT_LEN |=> st_q.flags[ugef_pkg::B_ISODROP])
    else $error("iso OUT drop not flagged");
  a_enum_speed: assert property (
    !ROLE_HOST && ENUM_DONE |=> st_q.flags[ugef_pkg::B_ENUM] && st_q.speed == $past(ENUM_SPEED))
    else $error("enumeration flag or speed missing");
  a_bus_reset: assert property (
    !ROLE_HOST && BUS_RESET |=> st_q.flags[ugef_pkg::B_BRST])
    else $error("bus reset not flagged");
  a_nptx_low: assert property (
    rd_flags && ROLE_HOST && NPTX_FREE == FW'(NPTX_DEPTH) |=> HRDATA[ugef_pkg::B_NPTX])
    else $error("empty tx FIFO not reported");
  a_oep_summary: assert property (
    rd_flags && !ROLE_HOST && OEP_IRQ |=> HRDATA[ugef_pkg::B_OEP])
    else $error("OUT endpoint summary not reported");
  a_iep_summary: assert property (
    rd_flags && !ROLE_HOST && IEP_IRQ |=> HRDATA[ugef_pkg::B_IEP])
    else $error("IN endpoint summary not reported");
  a_otg_summary: assert property (
    rd_flags && OTG_IRQ |=> HRDATA[ugef_pkg::B_OTG])
    else $error("OTG summary not reported");
  a_in_nak: assert property (
    $rose(st_q.in_act) |-> $past(st_q.in_req) && $past(XFER_IDLE))
    else $error("in NAK flag before request took effect");

  c_flag_clear: cover property (
    st_q.flags[ugef_pkg::B_SOF] ##1 !st_q.flags[ugef_pkg::B_SOF]);
  c_suspend: cover property ($rose(SUSPENDED));
  c_mode_fault: cover property ($rose(st_q.flags[ugef_pkg::B_MFLT]));
  c_nak_on: cover property ($rose(st_q.in_act));
endmodule : ugef_top

// *** logic/ugef_pkg.sv ***
// constants shared by the global event flag block
package ugef_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_BUSCFG  = 12'h000;
  localparam logic [11:0] ADDR_DEVCFG  = 12'h004;
  localparam logic [11:0] ADDR_DEVCTL  = 12'h008;
  localparam logic [11:0] ADDR_DEVSTAT = 12'h00C;
  localparam logic [11:0] ADDR_HOSTCFG = 12'h010;
  localparam logic [11:0] ADDR_FLAGS   = 12'h014;
  // ----------------------------------------------------------------
  // global_event_flags bit positions
  // ----------------------------------------------------------------
  localparam int B_ROLE    = 0;
  localparam int B_MFLT    = 1;
  localparam int B_OTG     = 2;
  localparam int B_SOF     = 3;
  localparam int B_RXNE    = 4;
  localparam int B_NPTX    = 5;
  localparam int B_INNAK   = 6;
  localparam int B_OUTNAK  = 7;
  localparam int B_IDLEW   = 10;
  localparam int B_SLEEP   = 11;
  localparam int B_BRST    = 12;
  localparam int B_ENUM    = 13;
  localparam int B_ISODROP = 14;
  localparam int B_PFEND   = 15;
  localparam int B_IEP     = 18;
  localparam int B_OEP     = 19;
  localparam int B_ISOIN   = 20;
  localparam int B_PINC    = 21;
  localparam int B_HPORT   = 24;
  localparam int B_HCH     = 25;
  // sticky bits that a written one clears
  localparam logic [31:0] W1C_MASK = 32'h0030_FC0A;
  // ----------------------------------------------------------------
  // control fields and reset values
  // ----------------------------------------------------------------
  localparam int DCTL_SET_OUT = 0;
  localparam int DCTL_SET_IN  = 1;
  localparam int DCTL_CLR_OUT = 2;
  localparam int DCTL_CLR_IN  = 3;
  localparam int DSTAT_SPD    = 1;
  localparam int DSTAT_FNUM   = 8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 25000;
  localparam int IDLE_TIME_MS = 3;
  localparam int IDLE_CYCLES  = IDLE_TIME_MS * CLK_KHZ;
  localparam int FRAME_BITS   = 12000;
  localparam int PF_PCT0      = 80;
  localparam int PF_PCT1      = 85;
  localparam int PF_PCT2      = 90;
  localparam int PF_PCT3      = 95;
  // bus slave states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR   = 3'b010,
    BUS_RD   = 3'b100
  } ugef_bus_t;
endpackage : ugef_pkg

// *** bench/tb_top.sv ***
// self-checking bench for the global event flag register block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // signals and short names
  // ----
  localparam int IDLE = 20; // short idle time keeps the run brief
  localparam int FW   = 9;
  localparam logic [11:0] FL = ugef_pkg::ADDR_FLAGS;
  localparam logic [11:0] DC = ugef_pkg::ADDR_DEVCFG;
  localparam logic [11:0] DT = ugef_pkg::ADDR_DEVCTL;
  localparam logic [11:0] DS = ugef_pkg::ADDR_DEVSTAT;
  localparam logic [11:0] HC = ugef_pkg::ADDR_HOSTCFG;
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  localparam int BP[5] = '{ugef_pkg::B_HCH, ugef_pkg::B_HPORT, ugef_pkg::B_OEP,
                           ugef_pkg::B_IEP, ugef_pkg::B_OTG};
  localparam int PCT[4] = '{ugef_pkg::PF_PCT0, ugef_pkg::PF_PCT1, ugef_pkg::PF_PCT2,
                            ugef_pkg::PF_PCT3};
  localparam logic [8:0] NF[4] = '{9'h080, 9'h07F, 9'h0FF, 9'h100};
  logic          SYS_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0]   HADDR, HWDATA, HRDATA, rd;
  logic [1:0]    HTRANS, ENUM_SPEED;
  logic [2:0]    HSIZE;
  logic          ROLE_HOST, HC_IRQ, HPORT_IRQ, OEP_IRQ, IEP_IRQ, OTG_IRQ, FRAME_END;
  logic          PERIODIC_PENDING, ISO_IN_PENDING, ISO_OUT_PENDING, ISO_OUT_PKT;
  logic          ENUM_DONE, BUS_RESET, BUS_IDLE, SOF_PREPARE, SOF_RX, XFER_IDLE;
  logic          OUT_NAK_REQ, IN_NAK_REQ, SUSPENDED, HOST_SOF_EN;
  logic [13:0]   BUS_TIME;
  logic [10:0]   FRAME_NUM;
  logic [FW-1:0] ISO_OUT_LEN, RX_FREE, RX_ENTRIES, NPTX_FREE;
  int            failures, tests_run;
  // ----
  // device under test
  // ----
  ugef_top #(.IDLE_CYCLES(IDLE), .FW(FW), .NPTX_DEPTH(256)) u_dut (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ROLE_HOST(ROLE_HOST), .HC_IRQ(HC_IRQ),
    .HPORT_IRQ(HPORT_IRQ), .OEP_IRQ(OEP_IRQ), .IEP_IRQ(IEP_IRQ), .OTG_IRQ(OTG_IRQ),
    .FRAME_END(FRAME_END), .PERIODIC_PENDING(PERIODIC_PENDING), .BUS_TIME(BUS_TIME),
    .ISO_IN_PENDING(ISO_IN_PENDING), .ISO_OUT_PENDING(ISO_OUT_PENDING),
    .ISO_OUT_PKT(ISO_OUT_PKT), .ISO_OUT_LEN(ISO_OUT_LEN), .RX_FREE(RX_FREE),
    .RX_ENTRIES(RX_ENTRIES), .NPTX_FREE(NPTX_FREE), .ENUM_DONE(ENUM_DONE),
    .ENUM_SPEED(ENUM_SPEED), .BUS_RESET(BUS_RESET), .BUS_IDLE(BUS_IDLE),
    .SOF_PREPARE(SOF_PREPARE), .SOF_RX(SOF_RX), .FRAME_NUM(FRAME_NUM),
    .XFER_IDLE(XFER_IDLE), .OUT_NAK_REQ(OUT_NAK_REQ), .IN_NAK_REQ(IN_NAK_REQ),
    .SUSPENDED(SUSPENDED), .HOST_SOF_EN(HOST_SOF_EN));
  // ----
  // shared tasks
  // ----
  function automatic logic [31:0] bm(input int b);
    return 32'h0000_0001 << b;
  endfunction : bm
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    tests_run++;
    if (act !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : tick
  // bounded wait so a stuck slave ends the run instead of hanging it
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 16);
    if (HREADYOUT !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask : wait_rdy
  // one single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR  <= {20'h0_0000, a};
    wait_rdy();
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    rd = HRDATA;
  endtask : bus
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, ugef_pkg::RESET_WORD);
    chk({30'h0, HREADYOUT, HRESP}, 32'h0000_0002);
    bus(1'b0, 12'h100, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : t_reset
  // each summary cause alone, both roles; the previous one must drop
  task automatic t_levels();
    logic [31:0] e;
    for (int h = 0; h < 2; h++) begin
      for (int i = 0; i < 5; i++) begin
        ROLE_HOST <= h[0];
        {HC_IRQ, HPORT_IRQ, OEP_IRQ, IEP_IRQ, OTG_IRQ} <= 5'h10 >> i;
        e = 32'(h);
        if (i == 4 || (i < 2) == (h == 1)) e = e | bm(BP[i]);
        bus(1'b0, FL, 32'h0000_0000);
        chk(rd, e);
      end
    end
    ROLE_HOST <= 1'b0;
    OTG_IRQ   <= 1'b0;
  endtask : t_levels
  task automatic t_events();
    logic [31:0] e;
    @(posedge SYS_CLK);
    {ENUM_DONE, BUS_RESET, SOF_RX, ISO_OUT_PKT} <= 4'hF;
    ENUM_SPEED  <= 2'h2;
    FRAME_NUM   <= 11'h5A3;
    ISO_OUT_LEN <= 9'h010;
    RX_FREE     <= 9'h00F;
    @(posedge SYS_CLK);
    {ENUM_DONE, BUS_RESET, SOF_RX, ISO_OUT_PKT} <= 4'h0;
    e = bm(ugef_pkg::B_ENUM) | bm(ugef_pkg::B_BRST) | bm(ugef_pkg::B_SOF)
      | bm(ugef_pkg::B_ISODROP);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, e);
    bus(1'b0, DS, 32'h0000_0000);
    chk(rd, {13'h0000, 11'h5A3, 5'h00, 2'h2, 1'b0});
    bus(1'b1, FL, ~e);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, e);
    bus(1'b1, FL, bm(ugef_pkg::B_SOF));
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, e & ~bm(ugef_pkg::B_SOF));
    bus(1'b1, FL, ONES);
    ISO_OUT_PKT <= 1'b1;
    RX_FREE     <= 9'h010; // exactly enough room: no drop
    @(posedge SYS_CLK);
    ISO_OUT_PKT <= 1'b0;
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : t_events
  task automatic t_host();
    ROLE_HOST        <= 1'b1;
    SOF_PREPARE      <= 1'b1;
    FRAME_END        <= 1'b1;
    PERIODIC_PENDING <= 1'b1;
    @(posedge SYS_CLK);
    {SOF_PREPARE, FRAME_END, PERIODIC_PENDING} <= 3'h0;
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h1 | bm(ugef_pkg::B_SOF) | bm(ugef_pkg::B_PINC));
    SOF_PREPARE <= 1'b1; // a set in the clearing data phase must win
    bus(1'b1, FL, ONES);
    {SOF_PREPARE, FRAME_END} <= 2'b01;
    @(posedge SYS_CLK);
    FRAME_END <= 1'b0;
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h1 | bm(ugef_pkg::B_SOF));
    bus(1'b1, FL, ONES);
    // free space on each side of both thresholds
    for (int i = 0; i < 4; i++) begin
      NPTX_FREE <= NF[i];
      bus(1'b1, 12'h000, 32'(i / 2));
      bus(1'b0, FL, 32'h0000_0000);
      chk(rd, 32'h1 | ((i % 3 == 0) ? bm(ugef_pkg::B_NPTX) : 32'h0));
    end
    NPTX_FREE  <= 9'h000;
    RX_ENTRIES <= 9'h001;
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h1 | bm(ugef_pkg::B_RXNE));
    RX_ENTRIES <= 9'h000;
    ROLE_HOST  <= 1'b0;
  endtask : t_host
  task automatic t_fault();
    bus(1'b1, DC, 32'h0000_0003);
    ROLE_HOST <= 1'b1;
    bus(1'b1, DC, 32'h0000_0000);
    bus(1'b1, HC, 32'h0000_0001);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    bus(1'b1, FL, ONES);
    ROLE_HOST <= 1'b0;
    bus(1'b0, DC, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    bus(1'b1, HC, 32'h0000_0000);
    chk({31'h0, HOST_SOF_EN}, 32'h0000_0001);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    bus(1'b1, FL, ONES);
  endtask : t_fault
  // bus time stops one short of each threshold, then reaches it
  task automatic t_periodic();
    int thr;
    ISO_IN_PENDING  <= 1'b1;
    ISO_OUT_PENDING <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      thr = ugef_pkg::FRAME_BITS * PCT[i] / 100;
      bus(1'b1, DC, 32'(i));
      BUS_TIME <= 14'(thr - 1);
      bus(1'b0, FL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      BUS_TIME <= 14'(thr);
      bus(1'b0, FL, 32'h0000_0000);
      chk(rd, bm(ugef_pkg::B_PFEND) | bm(ugef_pkg::B_ISOIN) | bm(ugef_pkg::B_PINC));
      bus(1'b1, FL, ONES);
      BUS_TIME <= 14'h0000;
    end
    {ISO_IN_PENDING, ISO_OUT_PENDING} <= 2'h0;
  endtask : t_periodic
  task automatic t_nak();
    bus(1'b1, DT, 32'h0000_0003);
    tick(3);
    chk({30'h0, IN_NAK_REQ, OUT_NAK_REQ}, 32'h0000_0003);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    XFER_IDLE <= 1'b1;
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, bm(ugef_pkg::B_OUTNAK) | bm(ugef_pkg::B_INNAK));
    bus(1'b1, DT, 32'h0000_000C);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : t_nak
  // a short burst of activity must restart the idle count
  task automatic t_idle();
    BUS_IDLE <= 1'b1;
    tick(IDLE - 5);
    BUS_IDLE <= 1'b0;
    tick(2);
    BUS_IDLE <= 1'b1;
    tick(IDLE - 5);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    tick(8);
    bus(1'b0, FL, 32'h0000_0000);
    chk(rd, bm(ugef_pkg::B_IDLEW) | bm(ugef_pkg::B_SLEEP));
    chk({31'h0, SUSPENDED}, 32'h0000_0001);
    BUS_IDLE <= 1'b0;
    tick(3);
    chk({31'h0, SUSPENDED}, 32'h0000_0000);
  endtask : t_idle
  // ----
  // clock and main sequence
  // ----
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    {RST_N, HSEL, HWRITE, HADDR, HWDATA, HTRANS, ENUM_SPEED, ROLE_HOST} = '0;
    {HC_IRQ, HPORT_IRQ, OEP_IRQ, IEP_IRQ, OTG_IRQ, FRAME_END, PERIODIC_PENDING} = '0;
    {ISO_IN_PENDING, ISO_OUT_PENDING, ISO_OUT_PKT, ENUM_DONE, BUS_RESET} = '0;
    {BUS_IDLE, SOF_PREPARE, SOF_RX, XFER_IDLE, BUS_TIME, FRAME_NUM} = '0;
    {ISO_OUT_LEN, RX_FREE, RX_ENTRIES, NPTX_FREE} = '0;
    HSIZE     = 3'h2;
    failures  = 0;
    tests_run = 0;
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_levels();
    t_events();
    t_host();
    t_fault();
    t_periodic();
    t_nak();
    t_idle();
    end_of_test();
  end
endmodule : tb_top
